// file: rtl/bbc_control_regs.sv
// Converter control registers behind a two-wire serial target, with soft start
//
// Contract
// RL1 - Serial register access works once supply and enable pin are up.
// RL2 - Setting output enable ramps reference from zero to programmed code in 3.6ms.
// RL3 - Enable pin low: shutdown, all functions off, registers back to defaults.
// RL4 - Output enable cleared: switching stops, serial interface stays active.
// RL5 - Output disabled with discharge-on-disable set: discharge until output below 0.8V.
// RL6 - Forced discharge bit turns discharge on regardless of output enable.
// RL7 - Controller keeps discharge on no longer than 10ms at a time.
// RL8 - External sync clock stays within 30 percent of resistor-set frequency.
// RL9 - Dithering off with external sync or pin outside window; else 7 percent.
// RL10 - Feedback source bit picks internal divider when 0, external when 1.
// RL11 - Two-bit divider field selects one of four feedback ratios.
// RL12 - Reference is an 11-bit code split over the two reference registers.
// RL13 - Three-bit cable droop field sets added voltage; default zero.
// RL14 - Current limit programmed as sense threshold in 0.5mV steps.
// RL15 - Current limit enable bit cleared stops current limiting.
// RL16 - Target address 75h with mode pin low, 74h with mode pin high.
// RL17 - Soft-start ramp advances monotonically in even steps to the code.
// RL18 - Registers are eight bits; a write acts when its data byte completes.
`timescale 1ns/100ps
module bbc_control_regs #(
  parameter int RAMP_CYCLES = bbc_pkg::RAMP_CYCLES
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      scl,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe,
  input  wire logic                      enable_uvlo_pin,
  input  wire logic                      mode_pin,
  input  wire logic                      vout_above_discharge,
  input  wire logic                      dither_sync_pin_in_window,
  input  wire logic                      dither_sync_pin_clocked,
  output bbc_pkg::bbc_ctrl_s             settings,
  output logic [bbc_pkg::REF_W-1:0]      ref_code,
  output logic                           ramp_done,
  output logic                           switching_enable,
  output logic                           discharge_enable,
  output logic                           dither_enable,
  output logic                           current_limit_active
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0]          en_sync;
  logic [1:0]          mode_sync;
  logic [1:0]          vout_sync;
  logic [1:0]          win_sync;
  logic [1:0]          ext_sync;
  logic [1:0]          scl_sync;
  logic [1:0]          sda_sync;
  logic [1:0]          tgl_sync;
  logic                scl_prev;
  logic                sda_prev;
  logic                tgl_prev;
  logic                en_s;
  logic                core_rst_n;
  logic                mode_latched;
  logic                bit_value;
  logic                bit_toggle;
  logic                bit_evt;
  logic                start_cond;
  logic                stop_cond;
  logic                scl_fall;
  logic                byte_done;
  logic [7:0]          byte_in;
  bbc_pkg::bbc_state_e state;
  logic [3:0]          bit_cnt;
  logic [7:0]          rx_shift;
  logic [7:0]          tx_shift;
  logic [7:0]          reg_ptr;
  logic                ack_flag;
  logic                read_dir;
  logic                wr_stb;
  logic [7:0]          reg_ref_low;
  logic [7:0]          reg_ref_high;
  logic [7:0]          reg_ilim;
  logic [7:0]          reg_fb_sel;
  logic [7:0]          reg_cable;
  logic [7:0]          reg_out_ctrl;

  // Register read decode, used for the first and every later read byte
  function automatic logic [7:0] read_reg(input logic [7:0] ptr);
    case (ptr)
      bbc_pkg::REG_REF_LOW:  read_reg = reg_ref_low;
      bbc_pkg::REG_REF_HIGH: read_reg = reg_ref_high;
      bbc_pkg::REG_ILIM:     read_reg = reg_ilim;
      bbc_pkg::REG_FB_SEL:   read_reg = reg_fb_sel;
      bbc_pkg::REG_CABLE:    read_reg = reg_cable;
      bbc_pkg::REG_OUT_CTRL: read_reg = reg_out_ctrl;
      default:               read_reg = 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two flops per asynchronous input; only bit 1 is read by logic
  always_ff @(posedge clk) begin
    en_sync   <= {en_sync[0], enable_uvlo_pin};
    mode_sync <= {mode_sync[0], mode_pin};
    vout_sync <= {vout_sync[0], vout_above_discharge};
    win_sync  <= {win_sync[0], dither_sync_pin_in_window};
    ext_sync  <= {ext_sync[0], dither_sync_pin_clocked};
    scl_sync  <= {scl_sync[0], scl};
    sda_sync  <= {sda_sync[0], sda_in};
    tgl_sync  <= {tgl_sync[0], bit_toggle};
  end

  // Edge history on the synchronised lines
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      tgl_prev <= 1'b0;
    end else begin
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
      tgl_prev <= tgl_sync[1];
    end
  end

  assign en_s       = en_sync[1];
  assign core_rst_n = rst_n & en_s; // [RL3]
  assign bit_evt    = tgl_sync[1] ^ tgl_prev;
  assign scl_fall   = scl_prev & ~scl_sync[1];
  assign start_cond = scl_prev & scl_sync[1] & sda_prev & ~sda_sync[1];
  assign stop_cond  = scl_prev & scl_sync[1] & ~sda_prev & sda_sync[1];
  assign byte_done  = bit_evt & (bit_cnt == 4'h7);
  assign byte_in    = {rx_shift[6:0], bit_value};
  assign sda_out    = 1'b0; // Open drain: only ever pulls low

  // Mode strap caught while held in shutdown, frozen once enabled
  always_ff @(posedge clk) begin
    if (!core_rst_n) begin
      mode_latched <= mode_sync[1];
    end
  end

  // Serial clock domain: captures data bits
  bbc_scl_sampler u_sampler (
    .scl        (scl),
    .rst_n      (rst_n),
    .sda_in     (sda_in),
    .bit_value  (bit_value),
    .bit_toggle (bit_toggle)
  );

  // ----------------------------------------------------------------
  // Serial target protocol
  // ----------------------------------------------------------------
  // Start and stop win over bit events; shutdown holds the target idle
  always_ff @(posedge clk) begin
    if (!core_rst_n) begin // [RL1]
      state    <= bbc_pkg::ST_IDLE;
      bit_cnt  <= 4'h0;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      reg_ptr  <= 8'h00;
      ack_flag <= 1'b0;
      read_dir <= 1'b0;
      sda_oe   <= 1'b0;
    end else if (start_cond || stop_cond) begin
      state    <= start_cond ? bbc_pkg::ST_ADDR : bbc_pkg::ST_IDLE;
      bit_cnt  <= 4'h0;
      ack_flag <= 1'b0;
      sda_oe   <= 1'b0;
    end else begin
      // Drive ack or read data while the clock is low
      if (scl_fall) begin
        if (bit_cnt == 4'h8 && ack_flag) begin
          sda_oe <= 1'b1;
        end else if (state == bbc_pkg::ST_RDATA && bit_cnt < 4'h8) begin
          sda_oe   <= ~tx_shift[7];
          tx_shift <= {tx_shift[6:0], 1'b0};
        end else begin
          sda_oe <= 1'b0;
        end
      end
      if (bit_evt && state != bbc_pkg::ST_IDLE) begin
        if (bit_cnt < 4'h8) begin
          rx_shift <= byte_in;
          bit_cnt  <= bit_cnt + 4'h1;
        end else begin
          bit_cnt  <= 4'h0;
          ack_flag <= 1'b0;
        end
        if (byte_done) begin
          case (state)
            bbc_pkg::ST_ADDR: begin
              if (byte_in[7:1] == (mode_latched ? bbc_pkg::ADDR_MODE_HIGH
                                                : bbc_pkg::ADDR_MODE_LOW)) begin // [RL16]
                ack_flag <= 1'b1;
                read_dir <= byte_in[0];
              end else begin
                state <= bbc_pkg::ST_IDLE;
              end
            end
            bbc_pkg::ST_PTR: begin
              reg_ptr  <= byte_in;
              ack_flag <= 1'b1;
            end
            bbc_pkg::ST_WDATA: begin
              reg_ptr  <= reg_ptr + 8'h01; // Auto-increment for bursts
              ack_flag <= 1'b1;
            end
            default: begin
              ack_flag <= 1'b0;
            end
          endcase
        end
        if (bit_cnt == 4'h8) begin
          case (state)
            bbc_pkg::ST_ADDR: begin
              state    <= read_dir ? bbc_pkg::ST_RDATA : bbc_pkg::ST_PTR;
              tx_shift <= read_reg(reg_ptr);
            end
            bbc_pkg::ST_PTR: begin
              state <= bbc_pkg::ST_WDATA;
            end
            bbc_pkg::ST_RDATA: begin
              // Controller ack low asks for the next byte; nack ends the read
              if (!bit_value) begin
                tx_shift <= read_reg(reg_ptr + 8'h01);
                reg_ptr  <= reg_ptr + 8'h01;
              end else begin
                state <= bbc_pkg::ST_IDLE;
              end
            end
            default: begin
              state <= state;
            end
          endcase
        end
      end
    end
  end

  // Write strobe on the last bit of a data byte, before its ack
  assign wr_stb = byte_done && state == bbc_pkg::ST_WDATA && !start_cond && !stop_cond; // [RL18]

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Shutdown returns every register to default
  always_ff @(posedge clk) begin
    if (!core_rst_n) begin // [RL3]
      reg_ref_low  <= bbc_pkg::RST_REF_LOW;
      reg_ref_high <= bbc_pkg::RST_REF_HIGH;
      reg_ilim     <= bbc_pkg::RST_ILIM;
      reg_fb_sel   <= bbc_pkg::RST_FB_SEL;
      reg_cable    <= bbc_pkg::RST_CABLE;
      reg_out_ctrl <= bbc_pkg::RST_OUT_CTRL;
    end else if (wr_stb) begin // [RL18]
      case (reg_ptr)
        bbc_pkg::REG_REF_LOW:  reg_ref_low  <= byte_in; // [RL12]
        bbc_pkg::REG_REF_HIGH: reg_ref_high <= byte_in & bbc_pkg::MASK_REF_HIGH;
        bbc_pkg::REG_ILIM:     reg_ilim     <= byte_in & bbc_pkg::MASK_ILIM;
        bbc_pkg::REG_FB_SEL:   reg_fb_sel   <= byte_in & bbc_pkg::MASK_FB_SEL;
        bbc_pkg::REG_CABLE:    reg_cable    <= byte_in & bbc_pkg::MASK_CABLE;
        bbc_pkg::REG_OUT_CTRL: reg_out_ctrl <= byte_in & bbc_pkg::MASK_OUT_CTRL;
        default:               reg_ref_low  <= reg_ref_low; // Unmapped: ignored
      endcase
    end
  end

  // Decoded settings to the analog side
  always_comb begin
    settings.output_enable          = reg_out_ctrl[bbc_pkg::OUT_EN_BIT];
    settings.forced_discharge       = reg_out_ctrl[bbc_pkg::FORCE_DIS_BIT];
    settings.discharge_on_disable   = reg_out_ctrl[bbc_pkg::DIS_ON_OFF_BIT];
    settings.feedback_source_select = reg_fb_sel[bbc_pkg::FB_SRC_BIT]; // [RL10]
    settings.internal_divider_ratio = reg_fb_sel[1:0]; // [RL11]
    settings.cable_droop_comp       = reg_cable[2:0]; // [RL13]
    settings.current_limit_en       = reg_ilim[bbc_pkg::ILIM_EN_BIT];
    settings.current_limit_code     = reg_ilim[6:0]; // [RL14]
    settings.ref_code_target        = {reg_ref_high[2:0], reg_ref_low}; // [RL12]
  end

  // ----------------------------------------------------------------
  // Converter control
  // ----------------------------------------------------------------
  bbc_soft_start #(
    .RAMP_CYCLES (RAMP_CYCLES)
  ) u_soft_start (
    .clk           (clk),
    .rst_n         (core_rst_n),
    .output_enable (settings.output_enable),
    .target        (settings.ref_code_target),
    .ref_code      (ref_code),
    .ramp_done     (ramp_done)
  ); // [RL2]

  // Switching, discharge, dither and limit gates; all off in shutdown
  always_ff @(posedge clk) begin
    if (!core_rst_n) begin
      switching_enable     <= 1'b0;
      discharge_enable     <= 1'b0;
      dither_enable        <= 1'b0;
      current_limit_active <= 1'b0;
    end else begin
      switching_enable     <= settings.output_enable; // [RL4]
      // Discharge length is left to the controller; no timer here
      discharge_enable     <= settings.forced_discharge // [RL6]
                              | (~settings.output_enable
                                 & settings.discharge_on_disable
                                 & vout_sync[1]); // [RL5]
      dither_enable        <= win_sync[1] & ~ext_sync[1]; // [RL9]
      current_limit_active <= settings.current_limit_en; // [RL15]
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_oe_write;
    wr_stb && reg_ptr == bbc_pkg::REG_OUT_CTRL;
  endsequence

  property p_oe_write_applies; // [RL18]
    s_oe_write |=> settings.output_enable == $past(byte_in[bbc_pkg::OUT_EN_BIT]);
  endproperty
  a_oe_write_applies: assert property (p_oe_write_applies) // [RL18]
    else $error("output control write not applied");

  property p_shutdown_defaults; // [RL3]
    !en_s |=> (reg_out_ctrl == bbc_pkg::RST_OUT_CTRL && reg_ilim == bbc_pkg::RST_ILIM
               && !discharge_enable && !switching_enable);
  endproperty
  a_shutdown_defaults: assert property (p_shutdown_defaults) // [RL3]
    else $error("shutdown did not restore defaults");

  property p_no_switch_when_off; // [RL4]
    (en_s && !settings.output_enable) |=> !switching_enable;
  endproperty
  a_no_switch_when_off: assert property (p_no_switch_when_off) // [RL4]
    else $error("switching while output disabled");

  property p_discharge_on_off; // [RL5]
    (en_s && !settings.output_enable && settings.discharge_on_disable && vout_sync[1])
      |=> discharge_enable;
  endproperty
  a_discharge_on_off: assert property (p_discharge_on_off) // [RL5]
    else $error("discharge missing after disable");

  property p_forced_discharge; // [RL6]
    (en_s && settings.forced_discharge) |=> discharge_enable;
  endproperty
  a_forced_discharge: assert property (p_forced_discharge) // [RL6]
    else $error("forced discharge not applied");

  property p_dither_off_sync; // [RL9]
    (ext_sync[1] || !win_sync[1]) |=> !dither_enable;
  endproperty
  a_dither_off_sync: assert property (p_dither_off_sync) // [RL9]
    else $error("dither left on with sync or pin outside window");

  property p_limit_off; // [RL15]
    !settings.current_limit_en |=> !current_limit_active;
  endproperty
  a_limit_off: assert property (p_limit_off) // [RL15]
    else $error("current limit active while disabled");

  sequence s_own_addr;
    byte_done && state == bbc_pkg::ST_ADDR && !start_cond && !stop_cond
      && byte_in[7:1] == (mode_latched ? 7'h74 : 7'h75);
  endsequence

  property p_addr_ack; // [RL16]
    s_own_addr |=> ack_flag ##[1:200] (sda_oe || start_cond || stop_cond);
  endproperty
  a_addr_ack: assert property (p_addr_ack) // [RL16]
    else $error("own address not acknowledged");

endmodule // bbc_control_regs

// file: rtl/bbc_pkg.sv
// Package: register map, field layout, reset values and timing of the converter control
package bbc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_REF_LOW  = 8'h00;
  localparam logic [7:0] REG_REF_HIGH = 8'h01;
  localparam logic [7:0] REG_ILIM     = 8'h02;
  localparam logic [7:0] REG_FB_SEL   = 8'h04;
  localparam logic [7:0] REG_CABLE    = 8'h05;
  localparam logic [7:0] REG_OUT_CTRL = 8'h06;

  // ----------------------------------------------------------------
  // Field positions and writable masks
  // ----------------------------------------------------------------
  localparam int         OUT_EN_BIT     = 7;
  localparam int         FORCE_DIS_BIT  = 5;
  localparam int         DIS_ON_OFF_BIT = 4;
  localparam int         FB_SRC_BIT     = 7;
  localparam int         ILIM_EN_BIT    = 7;
  localparam logic [7:0] MASK_REF_HIGH  = 8'h07;
  localparam logic [7:0] MASK_FB_SEL    = 8'h83;
  localparam logic [7:0] MASK_CABLE     = 8'h07;
  localparam logic [7:0] MASK_OUT_CTRL  = 8'hB0;
  localparam logic [7:0] MASK_ILIM      = 8'hFF;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_REF_LOW  = 8'h00;
  localparam logic [7:0] RST_REF_HIGH = 8'h00;
  localparam logic [7:0] RST_ILIM     = 8'hE4;
  localparam logic [7:0] RST_FB_SEL   = 8'h00;
  localparam logic [7:0] RST_CABLE    = 8'h00;
  localparam logic [7:0] RST_OUT_CTRL = 8'h00;

  // ----------------------------------------------------------------
  // Serial target addresses, selected by the mode pin
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_MODE_LOW  = 7'h75;
  localparam logic [6:0] ADDR_MODE_HIGH = 7'h74;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 20;
  localparam int SOFT_START_NS   = 3600000;
  localparam int RAMP_CYCLES     = SOFT_START_NS / CLK_PERIOD_NS;
  localparam int RAMP_W          = 18;
  localparam int REF_W           = 11;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_RDATA
  } bbc_state_e;

  typedef struct packed {
    logic             output_enable;
    logic             forced_discharge;
    logic             discharge_on_disable;
    logic             feedback_source_select;
    logic [1:0]       internal_divider_ratio;
    logic [2:0]       cable_droop_comp;
    logic             current_limit_en;
    logic [6:0]       current_limit_code;
    logic [REF_W-1:0] ref_code_target;
  } bbc_ctrl_s;

endpackage

// file: rtl/bbc_scl_sampler.sv
// Link-clock side: samples the data line on each rising serial clock edge
`timescale 1ns/100ps
module bbc_scl_sampler (
  input  wire logic scl,
  input  wire logic rst_n,
  input  wire logic sda_in,
  output logic      bit_value,
  output logic      bit_toggle
);

  // ----------------------------------------------------------------
  // Bit capture
  // ----------------------------------------------------------------
  // Value is held until the next edge, so the core reads it after the toggle syncs
  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      bit_value  <= 1'b0;
      bit_toggle <= 1'b0;
    end else begin
      bit_value  <= sda_in;
      bit_toggle <= ~bit_toggle;
    end
  end

endmodule // bbc_scl_sampler

// file: rtl/bbc_soft_start.sv
// Soft-start ramp of the reference code from zero to the programmed value
`timescale 1ns/100ps
module bbc_soft_start #(
  parameter int RAMP_CYCLES = bbc_pkg::RAMP_CYCLES
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      output_enable,
  input  wire logic [bbc_pkg::REF_W-1:0] target,
  output logic [bbc_pkg::REF_W-1:0]      ref_code,
  output logic                           ramp_done
);

  localparam logic [bbc_pkg::RAMP_W-1:0] RAMP_LEN = bbc_pkg::RAMP_W'(RAMP_CYCLES);

  logic [bbc_pkg::RAMP_W-1:0] acc;
  logic [bbc_pkg::RAMP_W-1:0] elapsed;
  logic [bbc_pkg::RAMP_W-1:0] next_acc;

  // Fraction accumulator: exactly target steps spread over the ramp
  assign next_acc = acc + bbc_pkg::RAMP_W'(target);

  // ----------------------------------------------------------------
  // Ramp
  // ----------------------------------------------------------------
  // Restarts from zero each time output enable rises
  always_ff @(posedge clk) begin
    if (!rst_n || !output_enable) begin
      ref_code  <= '0;
      acc       <= '0;
      elapsed   <= '0;
      ramp_done <= 1'b0;
    end else if (!ramp_done) begin
      elapsed <= elapsed + 1'b1;
      if (next_acc >= RAMP_LEN) begin // [RL17]
        acc      <= next_acc - RAMP_LEN;
        ref_code <= ref_code + 1'b1;
      end else begin
        acc <= next_acc;
      end
      if (elapsed == RAMP_LEN - 1'b1) begin // [RL2]
        ramp_done <= 1'b1;
      end
    end else begin
      ref_code <= target; // After the ramp, later writes apply directly
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_ramp_monotonic;
    @(posedge clk) disable iff (!rst_n)
      (output_enable && !ramp_done) |=> (ref_code >= $past(ref_code)); // [RL17]
  endproperty
  a_ramp_monotonic: assert property (p_ramp_monotonic) // [RL17]
    else $error("reference code fell during ramp");

  property p_ramp_from_zero;
    @(posedge clk) disable iff (!rst_n)
      $rose(output_enable) |-> ##1 (ref_code <= 11'h001); // [RL2]
  endproperty
  a_ramp_from_zero: assert property (p_ramp_from_zero) // [RL2]
    else $error("ramp did not start from zero");

endmodule // bbc_soft_start

// file: test/bbc_host_model.sv
// Serial bus controller model for the two-wire register port
`timescale 1ns/100ps
module bbc_host_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // Bus idles with clock high and data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Clock runs only inside frames; data moves mid-low, sampled at end of high
  task automatic slot(input logic b, output logic r);
    #100 sda_low = !b;
    #100 scl = 1'b1;
    #200 r = sda;
    scl = 1'b0;
  endtask
  // Start or repeated start (p=0), stop (p=1) leaving the bus free
  task automatic cond(input logic p);
    #100 sda_low = p;
    #100 scl = 1'b1;
    #200 sda_low = !p;
    if (!p) #200 scl = 1'b0;
  endtask
  // Byte MSB first; ninth slot sends rel (1 releases) and returns the ack
  task automatic xfer(input logic [7:0] d, input logic rel, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      slot(d[i], r);
      q[i] = r;
    end
    slot(rel, r);
    ack = !r;
  endtask
endmodule // bbc_host_model

// file: test/tb_top.sv
// Self-checking bench for the converter control registers
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0, rst_n = 1'b1, en = 1'b1, mode = 1'b0, vab = 1'b0, win = 1'b0, ext = 1'b0;
  logic        ak;
  logic [6:0]  adr = 7'h75;
  logic [7:0]  v;
  logic [10:0] prev;
  int          error_cnt = 0, tests_run = 0, cyc = 0;
  wire logic   scl, sda_low, sda, sda_out, sda_oe, ramp_done, sw_en, dis_en, dith_en, ilim_act;
  wire logic [10:0]   ref_code;
  bbc_pkg::bbc_ctrl_s st;
  // Rows: pointer, written byte, expected read-back
  logic [23:0] rows[7] = '{24'h00FFFF, 24'h01FF07, 24'h02B5B5, 24'h03FF00, 24'h04FF83,
                           24'h05FF07, 24'h067030};
  logic [7:0]  rstv[7] = '{8'h00, 8'h00, 8'hE4, 8'h00, 8'h00, 8'h00, 8'h00};
  // Open-drain data line with pull-up
  assign sda = (sda_oe ? sda_out : 1'b1) & !sda_low;
  bbc_host_model i_host (.scl(scl), .sda_low(sda_low), .sda(sda));
  bbc_control_regs #(.RAMP_CYCLES(64)) i_dut (
    .clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .enable_uvlo_pin(en), .mode_pin(mode), .vout_above_discharge(vab),
    .dither_sync_pin_in_window(win), .dither_sync_pin_clocked(ext), .settings(st),
    .ref_code(ref_code), .ramp_done(ramp_done), .switching_enable(sw_en),
    .discharge_enable(dis_en), .dither_enable(dith_en), .current_limit_active(ilim_act));
  always #10 clk = !clk;
  // Ceiling about three times the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) error_cnt++;
    if (cyc == 60000) wrap_up();
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // One transaction; a read turns the bus round with a repeated start
  task automatic xact(input logic [7:0] p, input logic [7:0] d, input logic rd);
    logic [7:0] q;
    logic k;
    i_host.cond(1'b0);
    i_host.xfer({adr, 1'b0}, 1'b1, q, ak);
    i_host.xfer(p, 1'b1, q, k);
    if (rd) begin
      i_host.cond(1'b0);
      i_host.xfer({adr, 1'b1}, 1'b1, q, k);
    end
    i_host.xfer(d, 1'b1, v, k);
    i_host.cond(1'b1);
    idle(1);
  endtask
  initial begin
    // A real falling edge, so the link-side sampler clears its toggle
    #1 rst_n = 1'b0;
    idle(6);
    rst_n = 1'b1;
    idle(6);
    for (int i = 0; i < 7; i++) begin
      xact(8'(i), 8'hFF, 1'b1);
      chk(v, rstv[i]);
      chk(ak, 1);
    end
    for (int i = 0; i < 7; i++) begin
      xact(rows[i][23:16], rows[i][15:8], 1'b0);
      xact(rows[i][23:16], 8'hFF, 1'b1);
      chk(v, rows[i][7:0]);
    end
    chk(st.ref_code_target, 11'h7FF);
    chk({st.feedback_source_select, st.internal_divider_ratio}, 3'h7);
    chk(st.cable_droop_comp, 3'h7);
    chk({st.current_limit_en, st.current_limit_code}, 8'hB5);
    chk({sw_en, dis_en, ilim_act}, 3'h3);
    // Forced discharge dropped quickly to bound its on time
    xact(8'h06, 8'h10, 1'b0);
    xact(8'h02, 8'h35, 1'b0);
    chk(ilim_act, 0);
    // Sync flag stands for an in-range external clock
    for (int i = 0; i < 8; i++) begin
      {vab, win, ext} = 3'(i);
      idle(6);
      chk(dis_en, vab);
      chk(dith_en, win & !ext);
    end
    // Small target so the shortened ramp can reach it
    xact(8'h00, 8'h28, 1'b0);
    xact(8'h01, 8'h00, 1'b0);
    xact(8'h06, 8'h80, 1'b0);
    prev = '0;
    for (int i = 0; i < 90 && ramp_done !== 1'b1; i++) begin
      chk(ref_code >= prev, 1);
      prev = ref_code;
      idle(1);
    end
    chk({sw_en, ramp_done, ref_code}, {2'h3, 11'd40});
    xact(8'h06, 8'h00, 1'b0);
    chk(sw_en, 0);
    adr = 7'h74;
    xact(8'h00, 8'h11, 1'b0);
    chk(ak, 0);
    // Shutdown with the strap high; the other address answers afterwards
    mode = 1'b1;
    en = 1'b0;
    idle(6);
    chk({st.ref_code_target, ramp_done}, 12'h0);
    en = 1'b1;
    idle(6);
    chk(ilim_act, 1);
    xact(8'h00, 8'hFF, 1'b1);
    chk({ak, v}, 9'h100);
    wrap_up();
  end
endmodule // tb_top
